// *** shared/imp_pkg.sv ***
`default_nettype none
package imp_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned RATE_LO_HZ = 100;
	localparam int unsigned RATE_HI_HZ = 200;
	localparam int unsigned DUTY_STEPS = 1024;
	localparam int unsigned SLOT_LO = CLK_HZ / (RATE_LO_HZ * DUTY_STEPS);
	localparam int unsigned SLOT_HI = CLK_HZ / (RATE_HI_HZ * DUTY_STEPS);
	localparam int unsigned PERIODIC_NS = 1000000;
	localparam int unsigned PERIODIC_CYC = PERIODIC_NS / 8;
	localparam int unsigned WORD_SHIFT = 2;
	localparam logic [11:0] IDX_MASK = 12'h009;
	localparam logic [11:0] IDX_PULSE = 12'h00A;
	localparam logic [11:0] IDX_SCRATCH = 12'h00B;
	localparam logic [11:0] OFF_MASK = IDX_MASK << WORD_SHIFT;
	localparam logic [11:0] OFF_PULSE = IDX_PULSE << WORD_SHIFT;
	localparam logic [11:0] OFF_SCRATCH = IDX_SCRATCH << WORD_SHIFT;
	localparam logic [11:0] OFF_STATUS = 12'h040;
	localparam logic [11:0] OFF_IEN = 12'h044;
	localparam logic [11:0] OFF_HSCFG = 12'h048;
	localparam logic [15:0] MASK_RST = 16'h0140;
	localparam logic [15:0] MASK_WMASK = 16'h01FF;
	localparam logic [15:0] PULSE_WMASK = 16'h7FF7;
	localparam logic [15:0] PULSE_KEEP = 16'h7FF0;
	localparam int unsigned BIT_PER = 8;
	localparam int unsigned BIT_WDOFF = 7;
	localparam int unsigned BIT_WDEV = 6;
	localparam int unsigned BIT_SPI = 5;
	localparam int unsigned BIT_RATE = 14;
	localparam int unsigned DUTY_LSB = 4;
	localparam int unsigned NGEN = 4;
	localparam int unsigned NSRC = 5;
	localparam logic [3:0] HS_GEN_BASE = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] SLOT_LO_C = SLOT_LO;
	localparam logic [31:0] SLOT_HI_C = SLOT_HI;
	typedef struct packed {
		logic rate;
		logic [9:0] duty;
	} imp_gen_cfg_s;
	typedef struct packed {
		logic [9:0] pos;
		logic [31:0] slot;
		logic done;
		logic out;
	} imp_gen_st_s;
	typedef struct packed {
		logic [15:0] mask;
		logic [2:0] bank;
		logic [15:0] scratch;
		logic [3:0] hscfg_unused;
		logic [15:0] hs_cfg;
		logic [7:0] status;
		logic [7:0] ien;
		logic awok;
		logic [11:0] awaddr;
		logic wok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] per_cnt;
		logic irq_pulse;
		logic [NSRC-1:0] src_q;
		logic [1:0] wdf_q;
	} imp_regs_s;
endpackage
`default_nettype wire

// *** core/imp_pulse_gen.sv ***
`default_nettype none
module imp_pulse_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire imp_pkg::imp_gen_cfg_s cfg,
	output logic pwm_out,
	output logic pwm_valid
);
	imp_pkg::imp_gen_st_s st_r;
	imp_pkg::imp_gen_st_s st_nxt;
	// Ten-bit position steps once per slot; duty compares against it.
	always_comb begin
		logic [31:0] lim;
		lim = cfg.rate ? imp_pkg::SLOT_HI_C : imp_pkg::SLOT_LO_C;
		st_nxt = st_r;
		if (st_r.slot >= lim - 32'h00000001) begin
			st_nxt.slot = 32'h00000000;
			st_nxt.pos = st_r.pos + 10'h001;
			if (st_r.pos == 10'h3FF) begin
				st_nxt.done = 1'b1;
			end
		end else begin
			st_nxt.slot = st_r.slot + 32'h00000001;
		end
		if (cfg.duty == 10'h3FF) begin
			st_nxt.out = 1'b1;
		end else begin
			st_nxt.out = (st_nxt.pos < cfg.duty);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign pwm_out = st_r.out;
	assign pwm_valid = st_r.done;
endmodule
`default_nettype wire

// *** core/imp_sw_mux.sv ***
`default_nettype none
module imp_sw_mux (
	input wire logic [15:0] hs_cfg,
	input wire logic [imp_pkg::NGEN-1:0] gen_out,
	output logic [3:0] hs_from_gen,
	output logic [3:0] hs_gen_sel
);
	// Codes four to seven hand a switch to one internal generator.
	for (genvar i = 0; i < 4; i++) begin : g_sw
		logic [3:0] code;
		logic [3:0] idx;
		assign code = hs_cfg[4*i +: 4];
		assign idx = code - imp_pkg::HS_GEN_BASE;
		assign hs_gen_sel[i] = (code[3:2] == 2'b01);
		assign hs_from_gen[i] = hs_gen_sel[i] & gen_out[idx[1:0]];
	end
endmodule
`default_nettype wire

// *** core/imp_regs.sv ***
`default_nettype none
module imp_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic restart,
	input wire logic normal_mode,
	input wire logic [4:0] summary_status,
	input wire logic serial_fail,
	input wire logic devmode_wd_fail,
	output logic devmode_watchdog_off,
	output logic irq_request_out,
	output logic irq_line,
	output logic [3:0] high_side_switch_n,
	output logic [3:0] hs_gen_sel,
	output logic [imp_pkg::NGEN-1:0] gen_valid
);
	imp_pkg::imp_regs_s r_r;
	imp_pkg::imp_regs_s r_nxt;
	imp_pkg::imp_gen_cfg_s [imp_pkg::NGEN-1:0] cfg_r;
	imp_pkg::imp_gen_cfg_s [imp_pkg::NGEN-1:0] cfg_nxt;
	logic [imp_pkg::NGEN-1:0] gen_out;
	logic [4:0] sum_s1_r;
	logic [4:0] sum_s2_r;
	logic [2:0] ev_s1_r;
	logic [2:0] ev_s2_r;
	logic [2:0] mode_s1_r;
	logic [2:0] mode_s2_r;
	logic do_wr;
	logic do_rd;
	logic [15:0] wd16;
	logic [15:0] pulse_view;
	logic [31:0] rd_val;
	logic rd_bad;
	logic wr_bad;
	localparam int unsigned NSRC_W = imp_pkg::NSRC;
	localparam logic [31:0] PER_LIM = imp_pkg::PERIODIC_CYC;
	logic [7:0] ev_new;
	logic [NSRC_W-1:0] rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sum_s1_r <= '0;
			sum_s2_r <= '0;
			ev_s1_r <= '0;
			ev_s2_r <= '0;
			mode_s1_r <= '0;
			mode_s2_r <= '0;
		end else begin
			sum_s1_r <= summary_status;
			sum_s2_r <= sum_s1_r;
			ev_s1_r <= {serial_fail, devmode_wd_fail, 1'b0};
			ev_s2_r <= ev_s1_r;
			mode_s1_r <= {restart, normal_mode, 1'b0};
			mode_s2_r <= mode_s1_r;
		end
	end

	for (genvar g = 0; g < imp_pkg::NGEN; g++) begin : g_gen
		imp_pulse_gen u_gen (
			.aclk(aclk),
			.aresetn(aresetn),
			.cfg(cfg_r[g]),
			.pwm_out(gen_out[g]),
			.pwm_valid(gen_valid[g])
		);
	end

	imp_sw_mux u_mux (
		.hs_cfg(r_r.hs_cfg),
		.gen_out(gen_out),
		.hs_from_gen(high_side_switch_n),
		.hs_gen_sel(hs_gen_sel)
	);

	assign do_wr = r_r.awok & r_r.wok & ~r_r.bvalid;
	assign do_rd = s_axi_arvalid & s_axi_arready;
	assign wd16 = r_r.wdata[15:0];
	assign pulse_view = {1'b0, cfg_r[r_r.bank[1:0]].rate, cfg_r[r_r.bank[1:0]].duty,
		1'b0, r_r.bank};
	assign rise = ~r_r.src_q & sum_s2_r;

	always_comb begin
		rd_bad = 1'b0;
		unique case (s_axi_araddr)
			imp_pkg::OFF_MASK: rd_val = {16'h0000, r_r.mask & imp_pkg::MASK_WMASK};
			imp_pkg::OFF_PULSE: rd_val = {16'h0000, pulse_view};
			imp_pkg::OFF_SCRATCH: rd_val = {16'h0000, r_r.scratch};
			imp_pkg::OFF_STATUS: rd_val = {24'h000000, r_r.status};
			imp_pkg::OFF_IEN: rd_val = {24'h000000, r_r.ien};
			imp_pkg::OFF_HSCFG: rd_val = {16'h0000, r_r.hs_cfg};
			default: begin
				rd_val = 32'h00000000;
				rd_bad = 1'b1;
			end
		endcase
	end

	always_comb begin
		wr_bad = 1'b0;
		unique case (r_r.awaddr)
			imp_pkg::OFF_MASK, imp_pkg::OFF_PULSE, imp_pkg::OFF_SCRATCH,
			imp_pkg::OFF_STATUS, imp_pkg::OFF_IEN, imp_pkg::OFF_HSCFG: wr_bad = 1'b0;
			default: wr_bad = 1'b1;
		endcase
	end

	always_comb begin
		r_nxt = r_r;
		cfg_nxt = cfg_r;
		ev_new = '0;
		r_nxt.src_q = sum_s2_r;
		r_nxt.wdf_q = ev_s2_r[2:1];
		r_nxt.irq_pulse = 1'b0;
		if (s_axi_awvalid && !r_r.awok) begin
			r_nxt.awok = 1'b1;
			r_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r_r.wok) begin
			r_nxt.wok = 1'b1;
			r_nxt.wdata = s_axi_wdata;
			r_nxt.wstrb = s_axi_wstrb;
		end
		if (r_r.bvalid && s_axi_bready) begin
			r_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			r_nxt.awok = 1'b0;
			r_nxt.wok = 1'b0;
			r_nxt.bvalid = 1'b1;
			r_nxt.bresp = wr_bad ? imp_pkg::RESP_SLVERR : imp_pkg::RESP_OKAY;
			if (&r_r.wstrb[1:0]) begin
				unique case (r_r.awaddr)
					imp_pkg::OFF_MASK: r_nxt.mask = wd16 & imp_pkg::MASK_WMASK;
					imp_pkg::OFF_PULSE: begin
						r_nxt.bank = wd16[2:0];
						if (!wd16[2]) begin
							cfg_nxt[wd16[1:0]].rate = wd16[imp_pkg::BIT_RATE];
							cfg_nxt[wd16[1:0]].duty = wd16[13:imp_pkg::DUTY_LSB];
						end
					end
					imp_pkg::OFF_SCRATCH: begin
						if (mode_s2_r[1]) begin
							r_nxt.scratch = wd16;
						end
					end
					imp_pkg::OFF_IEN: r_nxt.ien = wd16[7:0];
					imp_pkg::OFF_HSCFG: r_nxt.hs_cfg = wd16;
					default: r_nxt.mask = r_r.mask;
				endcase
			end
		end
		if (r_r.rvalid && s_axi_rready) begin
			r_nxt.rvalid = 1'b0;
		end
		if (do_rd) begin
			r_nxt.rvalid = 1'b1;
			r_nxt.rdata = rd_val;
			r_nxt.rresp = rd_bad ? imp_pkg::RESP_SLVERR : imp_pkg::RESP_OKAY;
			if (s_axi_araddr == imp_pkg::OFF_STATUS) begin
				r_nxt.status = '0;
			end
		end
		ev_new[4:0] = rise & r_r.mask[4:0];
		ev_new[imp_pkg::BIT_SPI] = ev_s2_r[2] & ~r_r.wdf_q[1] & r_r.mask[imp_pkg::BIT_SPI];
		ev_new[imp_pkg::BIT_WDEV] = ev_s2_r[1] & ~r_r.wdf_q[0] & r_r.mask[imp_pkg::BIT_WDEV];
		r_nxt.status = r_nxt.status | ev_new;
		if (|ev_new) begin
			r_nxt.irq_pulse = 1'b1;
		end
		if (r_r.mask[imp_pkg::BIT_PER] && (|(r_r.status & r_r.ien))) begin
			if (r_r.per_cnt >= PER_LIM - 32'h00000001) begin
				r_nxt.per_cnt = 32'h00000000;
				r_nxt.irq_pulse = 1'b1;
			end else begin
				r_nxt.per_cnt = r_r.per_cnt + 32'h00000001;
			end
		end else begin
			r_nxt.per_cnt = 32'h00000000;
		end
		if (mode_s2_r[2]) begin
			r_nxt.bank = 3'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_r <= '0;
			r_r.mask <= imp_pkg::MASK_RST;
			cfg_r <= '0;
		end else begin
			r_r <= r_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	assign s_axi_awready = ~r_r.awok;
	assign s_axi_wready = ~r_r.wok;
	assign s_axi_bvalid = r_r.bvalid;
	assign s_axi_bresp = r_r.bresp;
	assign s_axi_arready = ~r_r.rvalid;
	assign s_axi_rvalid = r_r.rvalid;
	assign s_axi_rdata = r_r.rdata;
	assign s_axi_rresp = r_r.rresp;
	assign devmode_watchdog_off = r_r.mask[imp_pkg::BIT_WDOFF];
	assign irq_request_out = r_r.irq_pulse;
	assign irq_line = |(r_r.status & r_r.ien);
endmodule
`default_nettype wire

// *** sim/imp_regs_props.sv ***
`default_nettype none
module imp_regs_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic devmode_watchdog_off,
	input wire logic [3:0] high_side_switch_n,
	input wire logic [3:0] hs_gen_sel
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_answer;
		s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000;
	endsequence
	property p_rd_lat;
		s_ar_taken |=> s_r_answer;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_w_block;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_rd_upper;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	property p_hs_route;
		(high_side_switch_n & ~hs_gen_sel) == 4'h0;
	endproperty
	property p_wd_rst;
		$rose(aresetn) |-> !devmode_watchdog_off;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	a_w_block: assert property (p_w_block) else $error("response before address and data");
	a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	a_hs_route: assert property (p_hs_route) else $error("unrouted switch driven");
	a_wd_rst: assert property (p_wd_rst) else $error("watchdog off after reset");
endmodule
bind imp_regs imp_regs_props imp_regs_props_inst (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .devmode_watchdog_off,
	.high_side_switch_n, .hs_gen_sel);
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, restart = 1'h0;
	logic normal_mode = 1'h1, serial_fail = 1'h0, devmode_wd_fail = 1'h0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hF, high_side_switch_n, hs_gen_sel, gen_valid;
	logic [4:0] summary_status = '0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic devmode_watchdog_off, irq_request_out, irq_line;
	int mismatches = 0, check_count = 0, c;
	imp_regs imp_regs_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .restart, .normal_mode, .summary_status,
		.serial_fail, .devmode_wd_fail, .devmode_watchdog_off, .irq_request_out, .irq_line,
		.high_side_switch_n, .hs_gen_sel, .gen_valid);
	initial forever #4 aclk = ~aclk;
	task automatic conclude;
		$display("mismatches=%0d check_count=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 60; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			if (tb) chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tb) break;
		end
		s_axi_bready <= 1'h0;
		@(posedge aclk);
		if (n == 60) begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 60; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			if (tr) chk({30'h0, s_axi_rresp}, {30'h0, er});
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'h0;
			if (tr) break;
		end
		s_axi_rready <= 1'h0;
		@(posedge aclk);
		if (n == 60) begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, imp_pkg::RESP_OKAY, d);
		chk(d, e);
	endtask
	task automatic fire(input int s, output int k);
		k = 0;
		if (s < 5) summary_status[s] <= 1'h1;
		else if (s == 5) serial_fail <= 1'h1;
		else devmode_wd_fail <= 1'h1;
		for (int n = 0; n < 16; n++) begin
			@(negedge aclk);
			if (irq_request_out === 1'h1) k++;
			@(posedge aclk);
			if (n == 7) begin
				summary_status <= '0;
				serial_fail <= 1'h0;
				devmode_wd_fail <= 1'h0;
			end
		end
	endtask
	task automatic t_regs;
		rdc(imp_pkg::OFF_MASK, 32'h00000140);
		rdc(imp_pkg::OFF_PULSE, 32'h00000000);
		rdc(imp_pkg::OFF_SCRATCH, 32'h00000000);
		wr(imp_pkg::OFF_MASK, 32'hFFFFFFFF, imp_pkg::RESP_OKAY);
		rdc(imp_pkg::OFF_MASK, 32'h000001FF);
		chk({31'h0, devmode_watchdog_off}, 32'h1);
		wr(imp_pkg::OFF_PULSE, 32'h0000FFFB, imp_pkg::RESP_OKAY);
		rdc(imp_pkg::OFF_PULSE, 32'h00007FF3);
	endtask
	task automatic t_keep;
		wr(imp_pkg::OFF_SCRATCH, 32'hFFFFA5C3, imp_pkg::RESP_OKAY);
		rdc(imp_pkg::OFF_SCRATCH, 32'h0000A5C3);
		s_axi_wstrb <= 4'hC;
		wr(imp_pkg::OFF_SCRATCH, 32'h00005A5A, imp_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rdc(imp_pkg::OFF_SCRATCH, 32'h0000A5C3);
		normal_mode <= 1'h0;
		repeat (4) @(posedge aclk);
		wr(imp_pkg::OFF_SCRATCH, 32'h00001234, imp_pkg::RESP_OKAY);
		normal_mode <= 1'h1;
		repeat (4) @(posedge aclk);
		rdc(imp_pkg::OFF_SCRATCH, 32'h0000A5C3);
		wr(imp_pkg::OFF_MASK, 32'h0000003F, imp_pkg::RESP_OKAY);
		wr(imp_pkg::OFF_PULSE, 32'h00004018, imp_pkg::RESP_OKAY);
		wr(imp_pkg::OFF_PULSE, 32'h00002341, imp_pkg::RESP_OKAY);
		rdc(imp_pkg::OFF_PULSE, 32'h00002341);
		restart <= 1'h1;
		repeat (6) @(posedge aclk);
		restart <= 1'h0;
		repeat (4) @(posedge aclk);
		rdc(imp_pkg::OFF_PULSE, 32'h00004010);
		wr(imp_pkg::OFF_PULSE, 32'h00007FF4, imp_pkg::RESP_OKAY);
		rdc(imp_pkg::OFF_PULSE, 32'h00004014);
		rdc(imp_pkg::OFF_MASK, 32'h0000003F);
		rdc(imp_pkg::OFF_SCRATCH, 32'h0000A5C3);
		chk({31'h0, devmode_watchdog_off}, 32'h0);
		rd(12'h100, imp_pkg::RESP_SLVERR, rv);
		chk(rv, 32'h0);
		wr(12'h100, 32'h000000FF, imp_pkg::RESP_SLVERR);
	endtask
	task automatic t_irq;
		wr(imp_pkg::OFF_IEN, 32'h000000FF, imp_pkg::RESP_OKAY);
		wr(imp_pkg::OFF_MASK, 32'h0000007F, imp_pkg::RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			fire(i, c);
			chk(c, 32'h1);
			chk({31'h0, irq_line}, 32'h1);
			rdc(imp_pkg::OFF_STATUS, 32'h1 << i);
			chk({31'h0, irq_line}, 32'h0);
		end
		fire(5, c);
		fire(5, c);
		chk(c, 32'h1);
		rdc(imp_pkg::OFF_STATUS, 32'h00000020);
		wr(imp_pkg::OFF_MASK, 32'h0000000F, imp_pkg::RESP_OKAY);
		fire(6, c);
		chk(c, 32'h0);
		fire(4, c);
		chk(c, 32'h0);
		wr(imp_pkg::OFF_IEN, 32'h00000000, imp_pkg::RESP_OKAY);
		fire(1, c);
		chk({31'h0, irq_line}, 32'h0);
		wr(imp_pkg::OFF_IEN, 32'h000000FF, imp_pkg::RESP_OKAY);
		rdc(imp_pkg::OFF_STATUS, 32'h00000002);
	endtask
	task automatic t_switch;
		wr(imp_pkg::OFF_PULSE, 32'h00000000, imp_pkg::RESP_OKAY);
		for (int k = 0; k < 9; k++) begin
			wr(imp_pkg::OFF_HSCFG, k, imp_pkg::RESP_OKAY);
			rdc(imp_pkg::OFF_HSCFG, k);
			chk({31'h0, hs_gen_sel[0]}, {31'h0, k >= 4 && k <= 7});
			if (k == 4) chk({31'h0, high_side_switch_n[0]}, 32'h0);
		end
		chk({28'h0, gen_valid}, 32'h0);
		wr(imp_pkg::OFF_PULSE, 32'h00003FF0, imp_pkg::RESP_OKAY);
		wr(imp_pkg::OFF_HSCFG, 32'h00000004, imp_pkg::RESP_OKAY);
		chk({31'h0, high_side_switch_n[0]}, 32'h1);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs();
		t_keep();
		t_irq();
		t_switch();
		conclude();
	end
endmodule
`default_nettype wire
